// >>> bst_cell_chain.sv
// Chain of boundary cells, one per monitored pin or interface bit
`timescale 1ns/10ps
module bst_cell_chain (
    // Clock and reset
    input  wire logic                         i_clk,
    input  wire logic                         i_rstn,
    // Controls from the port controller
    input  wire logic                         i_capture,
    input  wire logic                         i_shift,
    input  wire logic                         i_update,
    input  wire logic                         i_si,
    // Pins
    input  wire logic [bst_pkg::BST_BSR_W-1:0] i_pin,
    output logic      [bst_pkg::BST_BSR_W-1:0] o_upd,
    output logic                              o_so
);
    import bst_pkg::*;

    typedef struct packed {
        logic [BST_BSR_W-1:0] sh;
        logic [BST_BSR_W-1:0] upd;
    } bst_chain_type;

    bst_chain_type st_r;
    bst_chain_type st_nxt;

    // ----------------------------------------------------------------
    // Capture, shift toward bit 0, update
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (i_capture) begin
            st_nxt.sh = i_pin;
        end else if (i_shift) begin
            st_nxt.sh = {i_si, st_r.sh[BST_BSR_W-1:1]};
        end
        if (i_update) begin
            st_nxt.upd = st_r.sh;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_upd = st_r.upd;
    assign o_so  = st_r.sh[0];
endmodule

// >>> bst_pkg.sv
// Constants and types for the boundary-scan test port
package bst_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int BST_IR_W    = 4;
    localparam int BST_BSR_W   = 8;
    localparam int BST_ID_W    = 32;
    localparam int BST_VER_W   = 4;
    localparam int BST_PART_W  = 16;
    localparam int BST_MFR_W   = 11;

    // ----------------------------------------------------------------
    // Instruction codes
    // ----------------------------------------------------------------
    localparam logic [BST_IR_W-1:0] BST_OP_EXTEST = 4'h0;
    localparam logic [BST_IR_W-1:0] BST_OP_SAMPLE = 4'h1;
    localparam logic [BST_IR_W-1:0] BST_OP_IDCODE = 4'h2;
    localparam logic [BST_IR_W-1:0] BST_OP_BYPASS = 4'hF;
    localparam logic [BST_IR_W-1:0] BST_IR_CAPT   = 4'h1;

    // Identification fields; values are arbitrary
    localparam logic [BST_VER_W-1:0]  BST_ID_VER  = 4'h1;
    localparam logic [BST_PART_W-1:0] BST_ID_PART = 16'hA5C3;
    localparam logic [BST_MFR_W-1:0]  BST_ID_MFR  = 11'h123;
    localparam logic                  BST_ID_LSB  = 1'b1;

    // ----------------------------------------------------------------
    // Controller states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [15:0] {
        ST_RESET  = 16'h0001, ST_IDLE   = 16'h0002,
        ST_SELDR  = 16'h0004, ST_CAPDR  = 16'h0008,
        ST_SHDR   = 16'h0010, ST_EX1DR  = 16'h0020,
        ST_PADR   = 16'h0040, ST_EX2DR  = 16'h0080,
        ST_UPDR   = 16'h0100, ST_SELIR  = 16'h0200,
        ST_CAPIR  = 16'h0400, ST_SHIR   = 16'h0800,
        ST_EX1IR  = 16'h1000, ST_PAIR   = 16'h2000,
        ST_EX2IR  = 16'h4000, ST_UPIR   = 16'h8000
    } bst_state_type;

endpackage

// >>> bst_tap.sv
// Boundary-scan test access port controller, sampled on the system clock
`timescale 1ns/10ps
module bst_tap (
    // Clock and reset
    input  wire logic                          I_CLK,
    input  wire logic                          I_RSTN,
    // Test access pins
    input  wire logic                          I_TMS,
    input  wire logic                          I_TCK,
    input  wire logic                          I_TDI,
    input  wire logic                          I_TRSTN,
    output logic                               O_TDO,
    output logic                               O_TDO_OE,
    // Boundary pins
    input  wire logic [bst_pkg::BST_BSR_W-1:0] I_PIN_IN,
    input  wire logic [bst_pkg::BST_BSR_W-1:0] I_FUNC_OUT,
    output logic      [bst_pkg::BST_BSR_W-1:0] O_PIN_OUT,
    output logic                               O_TEST_MODE
);
    import bst_pkg::*;

    typedef struct packed {
        logic [1:0]          tms_s;
        logic [1:0]          tck_s;
        logic [1:0]          tdi_s;
        logic [1:0]          trst_s;
        logic                tck_d;
        bst_state_type       st;
        logic [BST_IR_W-1:0] ir_sh;
        logic [BST_IR_W-1:0] ir;
        logic [BST_ID_W-1:0] id_sh;
        logic                byp;
        logic                tdo;
        logic                oe;
    } bst_tap_type;

    bst_tap_type s_r;
    bst_tap_type s_nxt;

    logic tck_rise;
    logic tck_fall;
    logic trst_act;
    logic cap_dr;
    logic sh_dr;
    logic up_dr;
    logic bsr_sel;
    logic bsr_so;
    logic [BST_BSR_W-1:0] bsr_upd;

    // Next controller state for a test-clock rising edge
    function automatic bst_state_type next_state(input bst_state_type s, input logic m);
        case (s)
            ST_RESET: next_state = m ? ST_RESET : ST_IDLE;
            ST_IDLE:  next_state = m ? ST_SELDR : ST_IDLE;
            ST_SELDR: next_state = m ? ST_SELIR : ST_CAPDR;
            ST_CAPDR: next_state = m ? ST_EX1DR : ST_SHDR;
            ST_SHDR:  next_state = m ? ST_EX1DR : ST_SHDR;
            ST_EX1DR: next_state = m ? ST_UPDR  : ST_PADR;
            ST_PADR:  next_state = m ? ST_EX2DR : ST_PADR;
            ST_EX2DR: next_state = m ? ST_UPDR  : ST_SHDR;
            ST_UPDR:  next_state = m ? ST_SELDR : ST_IDLE;
            ST_SELIR: next_state = m ? ST_RESET : ST_CAPIR;
            ST_CAPIR: next_state = m ? ST_EX1IR : ST_SHIR;
            ST_SHIR:  next_state = m ? ST_EX1IR : ST_SHIR;
            ST_EX1IR: next_state = m ? ST_UPIR  : ST_PAIR;
            ST_PAIR:  next_state = m ? ST_EX2IR : ST_PAIR;
            ST_EX2IR: next_state = m ? ST_UPIR  : ST_SHIR;
            ST_UPIR:  next_state = m ? ST_SELDR : ST_IDLE;
            default:  next_state = ST_RESET;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Edge detection on the synchronised test clock
    // ----------------------------------------------------------------
    assign tck_rise = s_r.tck_s[1] & ~s_r.tck_d;
    assign tck_fall = ~s_r.tck_s[1] & s_r.tck_d;
    assign trst_act = ~s_r.trst_s[1];
    assign bsr_sel  = (s_r.ir == BST_OP_EXTEST) || (s_r.ir == BST_OP_SAMPLE);
    assign cap_dr   = tck_rise && !trst_act && (s_r.st == ST_CAPDR) && bsr_sel;
    assign sh_dr    = tck_rise && !trst_act && (s_r.st == ST_SHDR) && bsr_sel;
    assign up_dr    = tck_fall && !trst_act && (s_r.st == ST_UPDR) && bsr_sel;

    // ----------------------------------------------------------------
    // Controller
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt        = s_r;
        s_nxt.tms_s  = {s_r.tms_s[0], I_TMS};
        s_nxt.tck_s  = {s_r.tck_s[0], I_TCK};
        s_nxt.tdi_s  = {s_r.tdi_s[0], I_TDI};
        s_nxt.trst_s = {s_r.trst_s[0], I_TRSTN};
        s_nxt.tck_d  = s_r.tck_s[1];
        if (trst_act) begin
            s_nxt.st  = ST_RESET;
            s_nxt.ir  = BST_OP_IDCODE;
            s_nxt.oe  = 1'b0;
            s_nxt.tdo = 1'b0;
        end else if (tck_rise) begin
            case (s_r.st)
                ST_CAPIR: begin
                    s_nxt.ir_sh = BST_IR_CAPT;
                end
                ST_SHIR: begin
                    s_nxt.ir_sh = {s_r.tdi_s[1], s_r.ir_sh[BST_IR_W-1:1]};
                end
                ST_CAPDR: begin
                    s_nxt.id_sh = {BST_ID_VER, BST_ID_PART, BST_ID_MFR, BST_ID_LSB};
                    s_nxt.byp   = 1'b0;
                end
                ST_SHDR: begin
                    s_nxt.id_sh = {s_r.tdi_s[1], s_r.id_sh[BST_ID_W-1:1]};
                    s_nxt.byp   = s_r.tdi_s[1];
                end
                default: begin
                end
            endcase
            s_nxt.st = next_state(s_r.st, s_r.tms_s[1]);
        end else if (tck_fall) begin
            case (s_r.st)
                ST_UPIR: begin
                    s_nxt.ir = s_r.ir_sh;
                end
                ST_RESET: begin
                    s_nxt.ir = BST_OP_IDCODE;
                end
                default: begin
                end
            endcase
            s_nxt.oe = (s_r.st == ST_SHDR) || (s_r.st == ST_SHIR);
            if (s_r.st == ST_SHIR) begin
                s_nxt.tdo = s_r.ir_sh[0];
            end else begin
                case (s_r.ir)
                    BST_OP_EXTEST, BST_OP_SAMPLE: s_nxt.tdo = bsr_so;
                    BST_OP_IDCODE: s_nxt.tdo = s_r.id_sh[0];
                    default:       s_nxt.tdo = s_r.byp;
                endcase
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            s_r        <= '0;
            s_r.st     <= ST_RESET;
            s_r.ir     <= BST_OP_IDCODE;
            s_r.tck_s  <= 2'b00;
            s_r.trst_s <= 2'b00;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Boundary register
    // ----------------------------------------------------------------
    bst_cell_chain u_chain (
        .i_clk     (I_CLK),
        .i_rstn    (I_RSTN),
        .i_capture (cap_dr),
        .i_shift   (sh_dr),
        .i_update  (up_dr),
        .i_si      (s_r.tdi_s[1]),
        .i_pin     (I_PIN_IN),
        .o_upd     (bsr_upd),
        .o_so      (bsr_so)
    );

    assign O_TEST_MODE = (s_r.ir == BST_OP_EXTEST);
    assign O_PIN_OUT   = O_TEST_MODE ? bsr_upd : I_FUNC_OUT;
    assign O_TDO       = s_r.tdo;
    assign O_TDO_OE    = s_r.oe;
endmodule

// >>> bst_tap_monitor.sv
// Pin-level checks of the test port controller
`timescale 1ns/10ps
module bst_tap_monitor (
    // Clock and reset
    input wire logic                          I_CLK,
    input wire logic                          I_RSTN,
    // Test pins
    input wire logic                          I_TMS,
    input wire logic                          I_TCK,
    input wire logic                          I_TDI,
    input wire logic                          I_TRSTN,
    input wire logic                          O_TDO,
    input wire logic                          O_TDO_OE,
    // Boundary pins
    input wire logic [bst_pkg::BST_BSR_W-1:0] I_PIN_IN,
    input wire logic [bst_pkg::BST_BSR_W-1:0] I_FUNC_OUT,
    input wire logic [bst_pkg::BST_BSR_W-1:0] O_PIN_OUT,
    input wire logic                          O_TEST_MODE
);
    import bst_pkg::*;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN || !I_TRSTN);
    a_pin_func: assert property (!O_TEST_MODE |-> O_PIN_OUT == I_FUNC_OUT)
        else $error("pins off functional value");
    a_rst_quiet: assert property (disable iff (1'b0) !I_RSTN |=> !O_TDO && !O_TDO_OE)
        else $error("serial out active in reset");
    a_trst_quiet: assert property (disable iff (!I_RSTN)
        !I_TRSTN [*5] |-> !O_TDO_OE && !O_TEST_MODE) else $error("test reset ignored");
    a_tdo_stands: assert property (I_TCK [*6] |-> $stable(O_TDO) && $stable(O_TDO_OE))
        else $error("serial out moved while clock high");
    a_oe_after_fall: assert property ($rose(O_TDO_OE) |-> !I_TCK && !$past(I_TCK, 2))
        else $error("output enable rose outside low phase");
    a_tdo_on_fall: assert property ($changed(O_TDO) |-> !I_TCK)
        else $error("serial out changed while clock high");
    a_mode_on_fall: assert property ($changed(O_TEST_MODE) |-> !I_TCK)
        else $error("test mode changed while clock high");
    a_pin_hold: assert property (
        O_TEST_MODE && $past(O_TEST_MODE) && I_TCK |-> $stable(O_PIN_OUT))
        else $error("driven pins moved while clock high");
endmodule

bind bst_tap bst_tap_monitor mon (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_TMS(I_TMS), .I_TCK(I_TCK), .I_TDI(I_TDI),
    .I_TRSTN(I_TRSTN), .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE), .I_PIN_IN(I_PIN_IN),
    .I_FUNC_OUT(I_FUNC_OUT), .O_PIN_OUT(O_PIN_OUT), .O_TEST_MODE(O_TEST_MODE)
);

// >>> bst_tester.sv
// Board tester model driving four test pins and reading the fifth
`timescale 1ns/10ps
module bst_tester (
    // Clock
    input  wire logic i_clk,
    // Test pins
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe,
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    output logic      o_trstn
);
    // Idle pins: clock low, mode select high
    initial begin
        o_tck   = 1'b0;
        o_tms   = 1'b1;
        o_tdi   = 1'b0;
        o_trstn = 1'b1;
    end

    // Drive the test reset pin
    task automatic set_trst(input logic lvl);
        o_trstn = lvl;
    endtask

    // One test clock of 25 system clocks, serial out read before the rise
    task automatic tbit(input logic tms, input logic tdi, output logic tdo);
        @(negedge i_clk);
        o_tms = tms;
        o_tdi = tdi;
        repeat (12) @(negedge i_clk);
        // Undriven serial out reads inverted
        tdo   = i_tdo_oe ? i_tdo : ~i_tdo;
        o_tck = 1'b1;
        repeat (12) @(negedge i_clk);
        o_tck = 1'b0;
        o_tdi = ~tdi;
    endtask

    // From idle: select, capture, n shift bits, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic t;
        dout = 32'h0000_0000;
        tbit(1'b1, 1'b0, t);
        if (ir) tbit(1'b1, 1'b0, t);
        tbit(1'b0, 1'b0, t);
        tbit(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) begin
            tbit(i == n - 1, din[i], t);
            dout[i] = t;
        end
        tbit(1'b1, 1'b0, t);
        tbit(1'b0, 1'b0, t);
    endtask
endmodule

// >>> tb_bst_tap.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/10ps
module tb_bst_tap;
    import bst_pkg::*;
    logic                 clk = 1'b0;
    logic                 rstn = 1'b0;
    logic                 tck, tms, tdi, trstn, tdo, tdo_oe, test_mode;
    logic [BST_BSR_W-1:0] pin_in = 8'h00;
    logic [BST_BSR_W-1:0] func_out = 8'hC7;
    logic [BST_BSR_W-1:0] pin_out;
    logic [31:0]          d;
    int                   fails = 0;
    int                   cmp_count = 0;

    always #2.5 clk = ~clk;

    bst_tester tester (.i_clk(clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck), .o_tms(tms),
                       .o_tdi(tdi), .o_trstn(trstn));
    bst_tap dut (.I_CLK(clk), .I_RSTN(rstn), .I_TMS(tms), .I_TCK(tck), .I_TDI(tdi),
                 .I_TRSTN(trstn), .O_TDO(tdo), .O_TDO_OE(tdo_oe), .I_PIN_IN(pin_in),
                 .I_FUNC_OUT(func_out), .O_PIN_OUT(pin_out), .O_TEST_MODE(test_mode));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic t_idcode;
        logic t;
        tester.tbit(1'b0, 1'b0, t);
        check("oe idle", 32'h0000_0000, 32'({tdo_oe, test_mode}));
        tester.scan(1'b0, 32, 32'h0000_0000, d);
        check("idcode", {BST_ID_VER, BST_ID_PART, BST_ID_MFR, BST_ID_LSB}, d);
    endtask

    task automatic t_bypass;
        tester.scan(1'b1, 4, 32'(BST_OP_BYPASS), d);
        check("ir capture", 32'(BST_IR_CAPT), 32'(d[3:0]));
        tester.scan(1'b0, 8, 32'h0000_00B4, d);
        check("bypass", 32'h0000_0068, 32'(d[7:0]));
        tester.scan(1'b1, 4, 32'(BST_OP_IDCODE), d);
        tester.scan(1'b0, 32, 32'h0000_0000, d);
        check("idcode load", {BST_ID_VER, BST_ID_PART, BST_ID_MFR, BST_ID_LSB}, d);
    endtask

    task automatic t_sample;
        pin_in = 8'h3C;
        tester.scan(1'b1, 4, 32'(BST_OP_SAMPLE), d);
        tester.scan(1'b0, 8, 32'h0000_0096, d);
        check("sample", 32'h0000_003C, 32'(d[7:0]));
        check("func pins", 32'({1'b0, func_out}), 32'({test_mode, pin_out}));
    endtask

    task automatic t_extest;
        tester.scan(1'b1, 4, 32'(BST_OP_EXTEST), d);
        check("preload", 32'h0000_0196, 32'({test_mode, pin_out}));
        pin_in = 8'h81;
        tester.scan(1'b0, 8, 32'h0000_005A, d);
        check("extest", 32'h0000_815A, 32'({d[7:0], pin_out}));
    endtask

    task automatic t_trst;
        logic t;
        tester.tbit(1'b1, 1'b0, t);
        tester.tbit(1'b0, 1'b0, t);
        tester.tbit(1'b0, 1'b0, t);
        repeat (6) @(negedge clk);
        check("oe shift", 32'h0000_0001, 32'(tdo_oe));
        tester.set_trst(1'b0);
        repeat (8) @(negedge clk);
        check("trst", 32'h0000_00C7, 32'({tdo_oe, test_mode, pin_out}));
        tester.set_trst(1'b1);
        repeat (4) @(negedge clk);
        t_idcode;
    endtask

    task automatic t_tms_reset;
        logic t;
        tester.scan(1'b1, 4, 32'(BST_OP_EXTEST), d);
        check("mode set", 32'h0000_0001, 32'(test_mode));
        repeat (5) tester.tbit(1'b1, 1'b0, t);
        check("tms reset", 32'({1'b0, func_out}), 32'({test_mode, pin_out}));
    endtask

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        t_idcode;
        t_bypass;
        t_sample;
        t_extest;
        t_trst;
        t_tms_reset;
        stop_test;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test;
    end
endmodule
